// ===== design/mft_pkg.sv
// Package with register map, field layout and mode codes of the timer unit.
// Functional notes
// - In capture mode the counter waits for a pin event before counting.
// - Instance zero drives waveform output zero, instance one output one.
// - Each instance has four interrupt sources A to D on two lines.
// - Each source has a pending flag and enable; only enabled sources interrupt.
// - Sources A, B, C share line A; source D alone drives line B.
// - A sets on counter one reload from A in modes 1, 3, 4, or pin A edge in mode 2.
// - B sets on reload from B in mode 1, pin B edge in 2 and 4.
// - C sets on counter one underflow in mode 2; D on counter two events.
// - Each instance decodes its own base address with identical register set.
// - Nine registers sit at word offsets 0x00 through 0x20.
// - Counter one is 16 bits, upper bits reserved, not touched by reset.
// - Reading counter one returns the live count.
// - Reload registers A and B are 16 bits, readable, not reset.
// - Writes to reload A are ignored while the unit is disabled.
// - Writes to reload B are ignored while the unit is disabled.
// - Mode field codes mode 1, 2, 3, 4 as values 0 to 3.
// - On counter one underflow it reloads from reload A and continues; in mode 1 every second reload comes from reload B.
package mft_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] BASE_UNIT0 = 32'h40D0_0000;
  localparam logic [31:0] BASE_UNIT1 = 32'h40E0_0000;
  localparam logic [31:0] BASE_MASK = 32'hFFFF_FF00;
  localparam logic [7:0] OFS_CNT1 = 8'h00;
  localparam logic [7:0] OFS_RLA = 8'h04;
  localparam logic [7:0] OFS_RLB = 8'h08;
  localparam logic [7:0] OFS_CNT2 = 8'h0C;
  localparam logic [7:0] OFS_PRSC = 8'h10;
  localparam logic [7:0] OFS_CKC = 8'h14;
  localparam logic [7:0] OFS_MCTRL = 8'h18;
  localparam logic [7:0] OFS_ICTRL = 8'h1C;
  localparam logic [7:0] OFS_ICLR = 8'h20;
  // Mode control fields.
  localparam int MODE_LSB = 0;
  localparam int AEDG_BIT = 2;
  localparam int BEDG_BIT = 3;
  localparam int AEN_BIT = 4;
  localparam int BEN_BIT = 5;
  localparam int AOUT_BIT = 6;
  localparam int EN_BIT = 7;
  localparam logic [7:0] MCTRL_RST = 8'h00;
  // Interrupt control: enables in bits 3:0, pending read in bits 7:4.
  localparam int IEN_LSB = 0;
  localparam int PND_LSB = 4;
  localparam logic [3:0] IEN_RST = 4'h0;
  // Clock control: counter one select 2:0, counter two select 5:3.
  localparam int C1SEL_LSB = 0;
  localparam int C2SEL_LSB = 3;
  localparam logic [2:0] CSEL_OFF = 3'h0;
  localparam logic [2:0] CSEL_SYS = 3'h1;
  localparam logic [5:0] CKC_RST = 6'h00;
  localparam logic [7:0] PRSC_RST = 8'h00;
  localparam logic [15:0] PRESET_VAL = 16'hFFFF;
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h1;
  localparam logic [1:0] MODE_3 = 2'h2;
  localparam logic [1:0] MODE_4 = 2'h3;
  localparam int SRC_A = 0;
  localparam int SRC_B = 1;
  localparam int SRC_C = 2;
  localparam int SRC_D = 3;
endpackage

// ===== design/multifunction_timer.sv
// Register file, two down counters and interrupt flags of one timer unit.
`timescale 1ns/100ps
module multifunction_timer
  import mft_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = BASE_UNIT0,
  parameter int UNIT_INDEX = 0,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Timer pins
  input wire logic timer_pin_a,
  input wire logic timer_pin_b,
  output logic waveform_out_zero,
  output logic waveform_out_one,
  // System interrupt lines
  output logic irq_line_a,
  output logic irq_line_b
);
  typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT, RUN_COUNT} run_t;

  logic [CNT_W-1:0] counter_one_value, counter_two_value;
  logic [CNT_W-1:0] reload_capture_a, reload_capture_b;
  logic [7:0] mctrl_reg, clock_prescale, presc_cnt_reg;
  logic [5:0] ckc_reg;
  logic [3:0] source_irq_enable, source_pending_flag, pend_next;
  logic pin_a_reg, pin_b_reg, wave_reg, wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] read_mux;
  run_t run_reg, run_next;

  // Decode and field extraction.
  wire hit = (reg_addr & BASE_MASK) == BASE_ADDR;
  wire [7:0] ofs = reg_addr[7:0];
  wire wr_cnt1 = reg_wr && hit && ofs == OFS_CNT1;
  wire wr_rla = reg_wr && hit && ofs == OFS_RLA;
  wire wr_rlb = reg_wr && hit && ofs == OFS_RLB;
  wire wr_cnt2 = reg_wr && hit && ofs == OFS_CNT2;
  wire wr_prsc = reg_wr && hit && ofs == OFS_PRSC;
  wire wr_ckc = reg_wr && hit && ofs == OFS_CKC;
  wire wr_mctrl = reg_wr && hit && ofs == OFS_MCTRL;
  wire wr_ictrl = reg_wr && hit && ofs == OFS_ICTRL;
  wire wr_iclr = reg_wr && hit && ofs == OFS_ICLR;
  wire [1:0] mode_select_field = mctrl_reg[MODE_LSB +: 2];
  wire unit_enable_bit = mctrl_reg[EN_BIT];
  wire a_edge_rise = mctrl_reg[AEDG_BIT];
  wire b_edge_rise = mctrl_reg[BEDG_BIT];
  wire a_en = mctrl_reg[AEN_BIT];
  wire b_en = mctrl_reg[BEN_BIT];
  wire [2:0] c1_sel = ckc_reg[C1SEL_LSB +: 3];
  wire [2:0] c2_sel = ckc_reg[C2SEL_LSB +: 3];

  // Pin edges, taken as synchronous inputs.
  wire a_ev = a_edge_rise ? (timer_pin_a && !pin_a_reg)
                          : (!timer_pin_a && pin_a_reg);
  wire b_ev = b_edge_rise ? (timer_pin_b && !pin_b_reg)
                          : (!timer_pin_b && pin_b_reg);
  wire m_cap1 = mode_select_field == MODE_2;
  wire m_cap2 = mode_select_field == MODE_4;
  wire cap_a1 = m_cap1 && a_ev;
  wire cap_b1 = m_cap1 && b_ev;
  wire cap_b2 = m_cap2 && b_ev;

  // Prescaled tick; only the system clock source is modelled here.
  wire presc_tick = presc_cnt_reg == 8'h00;
  wire cap_mode = m_cap1 || m_cap2;
  wire run_ok = unit_enable_bit && (!cap_mode || run_reg == RUN_COUNT);
  wire tick1 = run_ok && presc_tick && c1_sel == CSEL_SYS;
  wire tick2 = run_ok && presc_tick && c2_sel == CSEL_SYS;
  wire uf1 = tick1 && counter_one_value == '0;
  wire uf2 = tick2 && counter_two_value == '0;
  // Mode 1 alternates reloads from A and B; wait_reg marks the B phase.
  wire m1 = mode_select_field == MODE_1;
  wire rel1_a = uf1 && !(m1 && wait_reg);
  wire rel1_b = uf1 && m1 && wait_reg;

  // Capture start: counting begins after the first pin event.
  always_comb begin
    run_next = run_reg;
    case (run_reg)
      RUN_IDLE: begin
        if (unit_enable_bit && cap_mode) begin
          run_next = RUN_WAIT;
        end
      end
      RUN_WAIT: begin
        if (!unit_enable_bit || !cap_mode) begin
          run_next = RUN_IDLE;
        end else if (a_ev || b_ev) begin
          run_next = RUN_COUNT;
        end
      end
      RUN_COUNT: begin
        if (!unit_enable_bit || !cap_mode) begin
          run_next = RUN_IDLE;
        end
      end
      default: run_next = RUN_IDLE;
    endcase
  end

  // Event sources per mode; set wins over clear.
  always_comb begin
    pend_next = source_pending_flag;
    if (wr_iclr) begin
      pend_next = source_pending_flag & ~reg_wdata[3:0];
    end
    case (mode_select_field)
      MODE_1: begin
        if (rel1_a) pend_next[SRC_A] = 1'b1;
        if (rel1_b) pend_next[SRC_B] = 1'b1;
        if (uf2) pend_next[SRC_D] = 1'b1;
      end
      MODE_2: begin
        if (a_ev) pend_next[SRC_A] = 1'b1;
        if (b_ev) pend_next[SRC_B] = 1'b1;
        if (uf1) pend_next[SRC_C] = 1'b1;
        if (uf2) pend_next[SRC_D] = 1'b1;
      end
      MODE_3: begin
        if (rel1_a) pend_next[SRC_A] = 1'b1;
        if (uf2) pend_next[SRC_D] = 1'b1;
      end
      MODE_4: begin
        if (rel1_a) pend_next[SRC_A] = 1'b1;
        if (b_ev) pend_next[SRC_B] = 1'b1;
        if (uf2) pend_next[SRC_D] = 1'b1;
      end
      default: pend_next = source_pending_flag;
    endcase
  end

  // Control registers with reset.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mctrl_reg <= MCTRL_RST;
      ckc_reg <= CKC_RST;
      clock_prescale <= PRSC_RST;
      presc_cnt_reg <= PRSC_RST;
      source_irq_enable <= IEN_RST;
      source_pending_flag <= 4'h0;
      pin_a_reg <= 1'b0;
      pin_b_reg <= 1'b0;
      wave_reg <= 1'b0;
      wait_reg <= 1'b0;
      run_reg <= RUN_IDLE;
      rdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_mctrl) mctrl_reg <= reg_wdata[7:0];
      if (wr_ckc) ckc_reg <= reg_wdata[5:0];
      if (wr_prsc) clock_prescale <= reg_wdata[7:0];
      presc_cnt_reg <= presc_tick ? clock_prescale : presc_cnt_reg - 8'h01;
      if (wr_ictrl) source_irq_enable <= reg_wdata[3:0];
      source_pending_flag <= pend_next;
      pin_a_reg <= timer_pin_a;
      pin_b_reg <= timer_pin_b;
      if (!unit_enable_bit) begin
        wave_reg <= mctrl_reg[AOUT_BIT];
      end else if (uf1 && a_en && !m_cap1) begin
        wave_reg <= !wave_reg;
      end
      if (uf1 && m1) wait_reg <= !wait_reg;
      run_reg <= run_next;
      rdata_reg <= reg_rd ? read_mux : 32'h0000_0000;
    end
  end

  // Counters and reload registers keep their content through reset.
  always_ff @(posedge core_clk) begin
    if (wr_cnt1) begin
      counter_one_value <= reg_wdata[CNT_W-1:0];
    end else if (cap_a1 && a_en) begin
      counter_one_value <= PRESET_VAL;
    end else if (cap_b1 && b_en) begin
      counter_one_value <= PRESET_VAL;
    end else if (rel1_a) begin
      counter_one_value <= reload_capture_a;
    end else if (rel1_b) begin
      counter_one_value <= reload_capture_b;
    end else if (tick1) begin
      counter_one_value <= counter_one_value - 1'b1;
    end
    if (wr_cnt2) begin
      counter_two_value <= reg_wdata[CNT_W-1:0];
    end else if (cap_b2 && b_en) begin
      counter_two_value <= PRESET_VAL;
    end else if (uf2) begin
      counter_two_value <= reload_capture_b;
    end else if (tick2) begin
      counter_two_value <= counter_two_value - 1'b1;
    end
    if (cap_a1 || (cap_b1 && b_en)) begin
      reload_capture_a <= counter_one_value;
    end else if (wr_rla && unit_enable_bit) begin
      reload_capture_a <= reg_wdata[CNT_W-1:0];
    end
    if (cap_b1 && !b_en) begin
      reload_capture_b <= counter_one_value;
    end else if (cap_b2) begin
      reload_capture_b <= counter_two_value;
    end else if (wr_rlb && unit_enable_bit) begin
      reload_capture_b <= reg_wdata[CNT_W-1:0];
    end
  end

  // Read selection; counters read live, reserved bits read zero.
  always_comb begin
    read_mux = 32'h0000_0000;
    if (hit) begin
      case (ofs)
        OFS_CNT1: read_mux[CNT_W-1:0] = counter_one_value;
        OFS_RLA: read_mux[CNT_W-1:0] = reload_capture_a;
        OFS_RLB: read_mux[CNT_W-1:0] = reload_capture_b;
        OFS_CNT2: read_mux[CNT_W-1:0] = counter_two_value;
        OFS_PRSC: read_mux[7:0] = clock_prescale;
        OFS_CKC: read_mux[5:0] = ckc_reg;
        OFS_MCTRL: read_mux[7:0] = mctrl_reg;
        OFS_ICTRL: begin
          read_mux[IEN_LSB +: 4] = source_irq_enable;
          read_mux[PND_LSB +: 4] = source_pending_flag;
        end
        OFS_ICLR: read_mux[3:0] = source_pending_flag;
        default: read_mux = 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata = rdata_reg;
  wire [3:0] gated = source_pending_flag & source_irq_enable;
  assign irq_line_a = gated[SRC_A] | gated[SRC_B] | gated[SRC_C];
  assign irq_line_b = gated[SRC_D];
  assign waveform_out_zero = (UNIT_INDEX == 0) ? wave_reg : 1'b0;
  assign waveform_out_one = (UNIT_INDEX == 1) ? wave_reg : 1'b0;
endmodule

// ===== tb/timer_regs_props.sv
// Checker of read timing, decoding and interrupt lines of one timer unit.
`timescale 1ns/100ps
module timer_regs_checker
  import mft_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = BASE_UNIT0,
  parameter int UNIT_INDEX = 0
) (
  // Clock, reset and register port
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Outputs
  input wire logic waveform_out_one,
  input wire logic irq_line_a,
  input wire logic irq_line_b
);
  wire hit = (reg_addr & BASE_MASK) == BASE_ADDR;
  wire [7:0] ofs = reg_addr[7:0];
  wire ictrl = hit && ofs == OFS_ICTRL;
  wire mctrl = hit && ofs == OFS_MCTRL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  upper_zero_a: assert property ($past(reg_rd) |-> reg_rdata[31:16] == 0)
    else $error("reserved bits read nonzero");
  unmapped_read_a: assert property ($past(reg_rd) &&
    ($past(!hit) || $past(ofs) > OFS_ICLR) |-> reg_rdata == 32'h0)
    else $error("unmapped read nonzero");
  ien_off_a: assert property (reg_wr && ictrl && reg_wdata[3:0] == 0
    |=> !irq_line_a && !irq_line_b) else $error("irq with enables off");
  irq_a_match_a: assert property ($past(reg_rd && ictrl) |->
    $past(irq_line_a) == |(reg_rdata[6:4] & reg_rdata[2:0]))
    else $error("line a differs from flags");
  irq_b_match_a: assert property ($past(reg_rd && ictrl) |->
    $past(irq_line_b) == (reg_rdata[7] & reg_rdata[3]))
    else $error("line b differs from flags");
  wave_one_a: assert property (UNIT_INDEX != 0 || !waveform_out_one)
    else $error("wrong waveform output used");
  ien_back_a: assert property (reg_wr && ictrl ##2 reg_rd && ictrl
    |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 3))
    else $error("enable readback wrong");
  mode_back_a: assert property (reg_wr && mctrl ##2 reg_rd && mctrl
    |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3))
    else $error("mode readback wrong");
endmodule
bind multifunction_timer timer_regs_checker #(.BASE_ADDR(BASE_ADDR),
  .UNIT_INDEX(UNIT_INDEX)) chk_i (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .waveform_out_one(waveform_out_one), .irq_line_a(irq_line_a),
  .irq_line_b(irq_line_b));

// ===== tb/dual_timer_irq_and_reload_regs_bench.sv
// Register-level bench of one timer unit.
`timescale 1ns/100ps
module dual_timer_irq_and_reload_regs_bench
  import mft_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] base = BASE_UNIT0;
  logic [31:0] reg_rdata, v, v2;
  logic reg_wr = 1'b0, reg_rd = 1'b0, timer_pin_a = 1'b0, timer_pin_b = 1'b0;
  logic waveform_out_zero, waveform_out_one, irq_line_a, irq_line_b, w;
  logic [7:0] ro;
  int n_errors = 0, total_checks = 0, cycles = 0, tog;
  multifunction_timer dut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_pin_a(timer_pin_a),
    .timer_pin_b(timer_pin_b), .waveform_out_zero(waveform_out_zero),
    .waveform_out_one(waveform_out_one), .irq_line_a(irq_line_a),
    .irq_line_b(irq_line_b));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] o, input logic [31:0] d);
    reg_addr <= base + o;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] o, output logic [31:0] q);
    reg_addr <= base + o;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge core_clk);
  endtask
  task rdchk(input string what, input logic [7:0] o, input logic [31:0] exp);
    logic [31:0] q;
    rd(o, q);
    chk(what, q, exp);
  endtask
  task irqchk(input logic ea, input logic eb);
    #1 chk("irq a", {31'h0, irq_line_a}, {31'h0, ea});
    chk("irq b", {31'h0, irq_line_b}, {31'h0, eb});
    @(posedge core_clk);
  endtask
  // Runs both counters from small values, then stops them and reads flags.
  task run(input logic [7:0] mc, input logic [31:0] exp);
    wr(OFS_CKC, 32'h0000_0000);
    wr(OFS_MCTRL, {24'h0, mc});
    wr(OFS_ICLR, 32'h0000_000F);
    wr(OFS_CNT1, 32'h0000_0002);
    wr(OFS_CNT2, 32'h0000_0002);
    wr(OFS_RLA, 32'h0000_0003);
    wr(OFS_RLB, 32'h0000_0003);
    wr(OFS_CKC, 32'h0000_0009);
    tog = 0;
    w = waveform_out_zero;
    repeat (40) begin
      @(posedge core_clk);
      #1 if (waveform_out_zero !== w) tog++;
      w = waveform_out_zero;
    end
    @(posedge core_clk);
    wr(OFS_CKC, 32'h0000_0000);
    rdchk("pending", OFS_ICTRL, exp);
    chk("toggle", {31'h0, tog > 0}, 32'h0000_0001);
    chk("out one", {31'h0, waveform_out_one}, 32'h0000_0000);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    base = BASE_UNIT1;
    wr(OFS_ICTRL, 32'h0000_000F);
    rdchk("other base", OFS_ICTRL, 32'h0000_0000);
    base = BASE_UNIT0;
    for (int o = 16; o <= 32; o += 4) rdchk("reset", o[7:0], 32'h0);
    rdchk("unmapped", 8'h24, 32'h0000_0000);
    wr(OFS_MCTRL, 32'h0000_0080);
    rdchk("mode ctrl", OFS_MCTRL, 32'h0000_0080);
    for (int i = 0; i < 2; i++) begin
      ro = i ? OFS_RLB : OFS_RLA;
      wr(OFS_MCTRL, 32'h0000_0080);
      wr(ro, 32'hFFFF_1234);
      wr(OFS_MCTRL, 32'h0000_0000);
      wr(ro, 32'h0000_5555);
      rdchk("reload", ro, 32'h0000_1234);
    end
    wr(OFS_ICTRL, 32'h0000_0000);
    run(8'h90, 32'h0000_00B0);
    wr(OFS_ICTRL, 32'h0000_0008);
    irqchk(1'b0, 1'b1);
    wr(OFS_ICTRL, 32'h0000_0001);
    rdchk("enables", OFS_ICTRL, 32'h0000_00B1);
    irqchk(1'b1, 1'b0);
    wr(OFS_ICLR, 32'h0000_0001);
    irqchk(1'b0, 1'b0);
    rdchk("cleared", OFS_ICTRL, 32'h0000_00A1);
    wr(OFS_ICTRL, 32'h0000_0000);
    run(8'h92, 32'h0000_0090);
    wr(OFS_CNT1, 32'h0000_0100);
    wr(OFS_CKC, 32'h0000_0001);
    rd(OFS_CNT1, v);
    rd(OFS_CNT1, v2);
    chk("live", {31'h0, v2 < v}, 32'h0000_0001);
    wr(OFS_CKC, 32'h0000_0000);
    wr(OFS_MCTRL, 32'h0000_0085);
    wr(OFS_ICLR, 32'h0000_000F);
    wr(OFS_CNT1, 32'h0000_0002);
    wr(OFS_CKC, 32'h0000_0001);
    repeat (20) @(posedge core_clk);
    rdchk("no start", OFS_ICTRL, 32'h0000_0000);
    timer_pin_a <= 1'b1;
    repeat (20) @(posedge core_clk);
    rdchk("capture", OFS_ICTRL, 32'h0000_0050);
    summarize();
  end
endmodule
